// *** hmc_cfg.svh ***
/*
  Constants of the host mailbox command port: command codes, status bit
  positions, buffer shape and times.
  Assumes a 25 MHz core clock; times are kept in ns and converted where used.
*/
// Overview of operation
// (RULE1) status byte layout: events, burst, command, full flags
// (RULE2) output full set on load, cleared by read
// (RULE3) input full set on write, cleared on consume
// (RULE4) command write latches byte, sets command flag
// (RULE5) data write latches byte, clears command flag
// (RULE6) host polls flags before each write or read
// (RULE7) os event flag set, then os interrupt
// (RULE8) management event flag set before management interrupt
// (RULE9) read: command, address, then byte returned
// (RULE10) write: command, address, data stored at address
// (RULE11) read/write transactions signal via os interrupts
// (RULE12) burst enter: set flag, acknowledge byte, interrupt
// (RULE13) burst falls back on idle or total timeout
// (RULE14) forced burst exit raises os interrupt
// (RULE15) burst keeps interrupts, answers within limit
// (RULE16) burst exit command clears flag, interrupts
// (RULE17) host sends burst exit after its sequence
// (RULE18) burst suspends background work except critical events
// (RULE19) query returns event cause, zero if none
// (RULE20) input full visible within one microsecond
// (RULE21) ignored bits zero, flags cleared by reset
// (RULE22) unknown command consumed without other effect
`ifndef HMC_CFG_SVH
`define HMC_CFG_SVH
`define HMC_CMD_READ    8'h80
`define HMC_CMD_WRITE   8'h81
`define HMC_CMD_BURST   8'h82
`define HMC_CMD_UNBURST 8'h83
`define HMC_CMD_QUERY   8'h84
`define HMC_BURST_ACK   8'h90
`define HMC_NO_EVENT    8'h00
`define HMC_ST_OBF      0
`define HMC_ST_IBF      1
`define HMC_ST_CMD      3
`define HMC_ST_BURST    4
`define HMC_ST_OSEVT    5
`define HMC_ST_MGEVT    6
`define HMC_FIFO_W      9
`define HMC_FIFO_D      16
`define HMC_CLK_NS      40
`define HMC_IBF_NS      1000
`define HMC_FIRST_NS    400000
`define HMC_NEXT_NS     50000
`define HMC_TOTAL_NS    1000000
`endif

// *** hmc_pkg.sv ***
/*
  Types of the host mailbox command port.
  Assumes hmc_cfg.svh for all numeric constants.
*/
package hmc_pkg;
  typedef logic [7:0] hmc_byte_t;
  typedef enum logic [2:0] {HMC_IDLE, HMC_RD_ADDR, HMC_RD_FETCH, HMC_WR_ADDR, HMC_WR_DATA} hmc_state_e;
endpackage

// *** hmc_port.sv ***
/*
  Host mailbox command port: host pin capture, input FIFO, command engine,
  burst timers and status byte, plus the FIFO module it uses.
  Assumes host strobes are asynchronous to clk and held several clocks;
  the address space lives outside and answers space_rdata in the same cycle.
*/
`timescale 1ns/1ps
`include "hmc_cfg.svh"

module hmc_fifo #(
  parameter int W = `HMC_FIFO_W,
  parameter int D = `HMC_FIFO_D
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = count != (AW+1)'(D);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      wr_ptr <= '0;
    else if (push)
      wr_ptr <= wr_ptr + 1'b1;

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      rd_ptr <= '0;
    else if (pop)
      rd_ptr <= rd_ptr + 1'b1;

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      count <= '0;
    else if (push != pop)
      count <= push ? count + 1'b1 : count - 1'b1;

  always_ff @(posedge clk)
    if (push)
      mem[wr_ptr] <= in_data;
endmodule

module hmc_port #(
  parameter int FIRST_CYCLES = `HMC_FIRST_NS / `HMC_CLK_NS,
  parameter int TOTAL_CYCLES = `HMC_TOTAL_NS / `HMC_CLK_NS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // host pins
  input  wire logic       host_sel_cmd,
  input  wire logic       host_rd,
  input  wire logic       host_wr,
  input  wire logic [7:0] host_wdata,
  output logic [7:0]      host_rdata,
  output logic            host_rdata_oe,
  // interrupts to host
  output logic            os_event_interrupt,
  output logic            management_interrupt,
  // controller events
  input  wire logic       os_event_req,
  input  wire logic [7:0] os_event_code,
  input  wire logic       mgmt_event_req,
  input  wire logic       mgmt_event_ack,
  input  wire logic       critical_event,
  output logic            background_hold,
  // address space
  output logic [7:0]      space_addr,
  output logic            space_wr,
  output logic [7:0]      space_wdata,
  input  wire logic [7:0] space_rdata
);
  localparam logic [14:0] FIRST_C = 15'(FIRST_CYCLES);
  localparam logic [14:0] TOTAL_C = 15'(TOTAL_CYCLES);
  localparam logic [14:0] NEXT_C  = 15'(`HMC_NEXT_NS / `HMC_CLK_NS);
  localparam int IBF_CYCLES = `HMC_IBF_NS / `HMC_CLK_NS;
  // half the allowed reply time: tighter, and keeps the delay range short
  localparam int ANSWER_MAX = `HMC_NEXT_NS / `HMC_CLK_NS / 2;

  logic [1:0]        rst_sync;
  logic              srst_n;
  logic [10:0]       pin_s0;
  logic [10:0]       pin_s1;
  logic              rd_prev;
  logic              wr_prev;
  logic              sel_s, rd_s, wr_s;
  logic              wr_rise, data_read;
  logic              fifo_in_ready, input_full, pop, pop_ready, needs_out;
  logic [8:0]        fifo_out;
  hmc_pkg::hmc_byte_t head, out_byte, status, next_out_byte;
  logic              head_cmd, load, output_full, cmd_flag;
  logic              os_event_pending, mgmt_event_pending, os_set_d, mgmt_set_d;
  logic              burst, first_seen, burst_drop, next_os_irq;
  logic [14:0]       idle_cnt, total_cnt;
  hmc_pkg::hmc_state_e state;

  // reset released through two flops
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  assign srst_n = rst_sync[1];

  // host pins cross into clk; edges are taken from the second stage only
  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
    begin
      pin_s0 <= 11'h000;
      pin_s1 <= 11'h000;
    end
    else
    begin
      pin_s0 <= {host_sel_cmd, host_rd, host_wr, host_wdata};
      pin_s1 <= pin_s0;
    end
  assign {sel_s, rd_s, wr_s} = pin_s1[10:8];

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
    begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end
    else
    begin
      rd_prev <= rd_s;
      wr_prev <= wr_s;
    end
  assign wr_rise   = wr_s & !wr_prev;
  // flag cleared at the end of the read so the byte is not pulled mid-cycle
  assign data_read = rd_prev & !rd_s & !sel_s;

  // host byte tagged with its port goes into the input FIFO
  hmc_fifo #(.W(`HMC_FIFO_W), .D(`HMC_FIFO_D)) u_fifo (
    .clk       (clk),
    .srst_n    (srst_n),
    .in_valid  (wr_rise), // [RULE20]
    .in_ready  (fifo_in_ready),
    .in_data   ({sel_s, pin_s1[7:0]}),
    .out_valid (input_full),
    .out_ready (pop_ready),
    .out_data  (fifo_out)
  );
  assign head     = fifo_out[7:0];
  assign head_cmd = fifo_out[8];

  // engine stalls while its answer cannot go out, so the FIFO backs up
  assign needs_out = head_cmd & (head == `HMC_CMD_BURST || head == `HMC_CMD_QUERY);
  assign pop_ready = (state != hmc_pkg::HMC_RD_FETCH) & !(needs_out & output_full);
  assign pop       = input_full & pop_ready; // [RULE3]

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      cmd_flag <= 1'b0; // [RULE21]
    else if (wr_rise & fifo_in_ready)
      cmd_flag <= sel_s; // [RULE4] [RULE5]

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      state <= hmc_pkg::HMC_IDLE;
    else if (pop & head_cmd)
      case (head)
        `HMC_CMD_READ:  state <= hmc_pkg::HMC_RD_ADDR; // [RULE9]
        `HMC_CMD_WRITE: state <= hmc_pkg::HMC_WR_ADDR; // [RULE10]
        default:        state <= hmc_pkg::HMC_IDLE; // [RULE22]
      endcase
    else
      case (state)
        hmc_pkg::HMC_RD_ADDR:  if (pop) state <= hmc_pkg::HMC_RD_FETCH;
        hmc_pkg::HMC_RD_FETCH: if (!output_full) state <= hmc_pkg::HMC_IDLE;
        hmc_pkg::HMC_WR_ADDR:  if (pop) state <= hmc_pkg::HMC_WR_DATA;
        hmc_pkg::HMC_WR_DATA:  if (pop) state <= hmc_pkg::HMC_IDLE;
        default:               state <= hmc_pkg::HMC_IDLE;
      endcase

  // address space access
  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      space_addr <= 8'h00;
    else if (pop & !head_cmd & (state == hmc_pkg::HMC_RD_ADDR || state == hmc_pkg::HMC_WR_ADDR))
      space_addr <= head; // [RULE9] [RULE10]

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
    begin
      space_wr    <= 1'b0;
      space_wdata <= 8'h00;
    end
    else
    begin
      space_wr    <= pop & !head_cmd & (state == hmc_pkg::HMC_WR_DATA); // [RULE10]
      space_wdata <= head;
    end

  // output buffer loads: read result, burst acknowledge, query answer
  always_comb
  begin
    load          = 1'b0;
    next_out_byte = out_byte;
    if (state == hmc_pkg::HMC_RD_FETCH && !output_full)
    begin
      load          = 1'b1;
      next_out_byte = space_rdata; // [RULE9]
    end
    else if (pop & head_cmd & (head == `HMC_CMD_BURST))
    begin
      load          = 1'b1;
      next_out_byte = `HMC_BURST_ACK; // [RULE12]
    end
    else if (pop & head_cmd & (head == `HMC_CMD_QUERY))
    begin
      load          = 1'b1;
      next_out_byte = os_event_pending ? os_event_code : `HMC_NO_EVENT; // [RULE19]
    end
  end

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      out_byte <= 8'h00;
    else if (load)
      out_byte <= next_out_byte;

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      output_full <= 1'b0;
    else if (load)
      output_full <= 1'b1; // [RULE2]
    else if (data_read)
      output_full <= 1'b0; // [RULE2]

  // event flags: a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      os_event_pending <= 1'b0;
    else if (os_event_req)
      os_event_pending <= 1'b1; // [RULE7]
    else if (pop & head_cmd & (head == `HMC_CMD_QUERY))
      os_event_pending <= 1'b0; // [RULE19]

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      mgmt_event_pending <= 1'b0;
    else if (mgmt_event_req)
      mgmt_event_pending <= 1'b1; // [RULE8]
    else if (mgmt_event_ack)
      mgmt_event_pending <= 1'b0;

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
    begin
      os_set_d             <= 1'b0;
      mgmt_set_d           <= 1'b0;
      management_interrupt <= 1'b0;
    end
    else
    begin
      os_set_d             <= os_event_req;
      mgmt_set_d           <= mgmt_event_req;
      management_interrupt <= mgmt_set_d; // [RULE8]
    end

  // burst timing: idle limit is longer before the first access
  assign burst_drop = burst & (critical_event // [RULE14]
                    | idle_cnt == (first_seen ? NEXT_C : FIRST_C) - 15'h0001
                    | total_cnt == TOTAL_C - 15'h0001); // [RULE13]

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      burst <= 1'b0;
    else if (pop & head_cmd & (head == `HMC_CMD_BURST))
      burst <= 1'b1; // [RULE12]
    else if (pop & head_cmd & (head == `HMC_CMD_UNBURST))
      burst <= 1'b0; // [RULE16]
    else if (burst_drop)
      burst <= 1'b0;

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
    begin
      idle_cnt   <= 15'h0000;
      total_cnt  <= 15'h0000;
      first_seen <= 1'b0;
    end
    else if (!burst || (pop & head_cmd & (head == `HMC_CMD_BURST)))
    begin
      idle_cnt   <= 15'h0000;
      total_cnt  <= 15'h0000;
      first_seen <= 1'b0;
    end
    else
    begin
      idle_cnt   <= pop ? 15'h0000 : idle_cnt + 15'h0001; // [RULE13]
      total_cnt  <= total_cnt + 15'h0001;
      first_seen <= first_seen | pop;
    end

  assign background_hold = burst & !critical_event; // [RULE18]

  // os interrupt causes follow the per-command pattern, burst included
  always_comb
  begin
    next_os_irq = os_set_d | load | burst_drop; // [RULE7] [RULE14] [RULE15]
    if (pop & head_cmd)
      next_os_irq = next_os_irq | head == `HMC_CMD_READ | head == `HMC_CMD_WRITE
                  | head == `HMC_CMD_UNBURST; // [RULE11] [RULE16]
    else if (pop & (state == hmc_pkg::HMC_WR_ADDR || state == hmc_pkg::HMC_WR_DATA))
      next_os_irq = 1'b1; // [RULE11]
  end

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      os_event_interrupt <= 1'b0;
    else
      os_event_interrupt <= next_os_irq;

  always_comb
  begin
    status                = 8'h00; // [RULE21]
    status[`HMC_ST_OBF]   = output_full;
    status[`HMC_ST_IBF]   = input_full;
    status[`HMC_ST_CMD]   = cmd_flag;
    status[`HMC_ST_BURST] = burst;
    status[`HMC_ST_OSEVT] = os_event_pending;
    status[`HMC_ST_MGEVT] = mgmt_event_pending; // [RULE1]
  end

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
    begin
      host_rdata    <= 8'h00;
      host_rdata_oe <= 1'b0;
    end
    else
    begin
      host_rdata    <= sel_s ? status : out_byte; // [RULE1] [RULE2]
      host_rdata_oe <= rd_s;
    end

  status_ign_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE21]
    host_rdata_oe && sel_s |-> host_rdata[7] == 1'b0 && host_rdata[2] == 1'b0)
    else $error("ignored status bits not zero");
  obf_clear_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE2]
    data_read && !load |=> !output_full)
    else $error("output full not cleared by data read");
  ibf_set_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE20]
    $rose(pin_s0[8]) ##1 pin_s1[8] && !wr_prev && fifo_in_ready |-> ##[1:IBF_CYCLES] input_full)
    else $error("input full late after host write");
  cmd_flag_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE4]
    wr_rise && fifo_in_ready |=> cmd_flag == $past(sel_s) && input_full)
    else $error("command flag does not follow written port");
  mgmt_order_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE8]
    management_interrupt |-> $past(mgmt_event_pending) && $past(mgmt_set_d))
    else $error("management interrupt without pending flag");
  burst_ack_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE12]
    pop && head_cmd && head == `HMC_CMD_BURST |=> burst && output_full && out_byte == `HMC_BURST_ACK
    ##0 os_event_interrupt)
    else $error("burst enter not acknowledged");
  burst_exit_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE16]
    pop && head_cmd && head == `HMC_CMD_UNBURST |=> !burst && os_event_interrupt)
    else $error("burst exit command not honoured");
  unknown_cmd_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE22]
    pop && head_cmd && (head < `HMC_CMD_READ || head > `HMC_CMD_QUERY)
    |=> burst == ($past(burst) & !$past(burst_drop))
    && out_byte == $past(out_byte) && state == hmc_pkg::HMC_IDLE)
    else $error("unknown command had an effect");
  read_reply_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE9]
    state == hmc_pkg::HMC_RD_FETCH && !output_full |=> output_full && out_byte == $past(space_rdata))
    else $error("read result not loaded");
  burst_idle_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE13]
    burst |-> idle_cnt < (first_seen ? NEXT_C : FIRST_C) && total_cnt < TOTAL_C)
    else $error("burst outlived its time limit");
  answer_time_a: assert property (@(posedge clk) disable iff (!srst_n) // [RULE15]
    burst && input_full && !output_full && state != hmc_pkg::HMC_RD_FETCH |-> ##[0:ANSWER_MAX] !input_full)
    else $error("burst access not answered in time");
endmodule

// *** hmc_space_model.sv ***
/*
  Behavioural model of the controller address space behind the mailbox port.
  Assumes space_rdata may be combinational on space_addr; writes land on clk.
*/
`timescale 1ns/1ps

module hmc_space_model (
  // clock
  input  wire logic       clk,
  // access
  input  wire logic [7:0] space_addr,
  input  wire logic       space_wr,
  input  wire logic [7:0] space_wdata,
  output logic [7:0]      space_rdata
);
  logic [7:0] mem [256];

  // byte i starts at i inverted, so a dropped write cannot pass as stored
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'hFF;
  end

  // plain always: the bench also preloads bytes through the hierarchy
  always @(posedge clk)
  begin
    if (space_wr)
      mem[space_addr] <= space_wdata;
  end

  assign space_rdata = mem[space_addr];
endmodule

// *** testbench.sv ***
/*
  Self-checking bench for hmc_port: host reads and writes through the pins,
  command sequences, events, burst entry, exit and fall-back.
  Assumes short burst counts set by parameter; host strobes held 4 to 5 clocks.
*/
`timescale 1ns/1ps

module testbench;
  logic              clk;
  logic              rst_n;
  logic              host_sel_cmd;
  logic              host_rd;
  logic              host_wr;
  hmc_pkg::hmc_byte_t host_wdata;
  hmc_pkg::hmc_byte_t host_rdata;
  logic              host_rdata_oe;
  logic              os_event_interrupt;
  logic              management_interrupt;
  logic              os_event_req;
  hmc_pkg::hmc_byte_t os_event_code;
  logic              mgmt_event_req;
  logic              mgmt_event_ack;
  logic              critical_event;
  logic              background_hold;
  logic [7:0]        space_addr;
  logic              space_wr;
  logic [7:0]        space_wdata;
  logic [7:0]        space_rdata;
  int                failures;
  int                n_compared;
  int                os_cnt;
  int                mg_cnt;
  int                c;
  hmc_pkg::hmc_byte_t s;

  hmc_port #(.FIRST_CYCLES(400), .TOTAL_CYCLES(1000)) dut_u (
    .clk(clk), .rst_n(rst_n), .host_sel_cmd(host_sel_cmd), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .os_event_interrupt(os_event_interrupt),
    .management_interrupt(management_interrupt), .os_event_req(os_event_req),
    .os_event_code(os_event_code), .mgmt_event_req(mgmt_event_req),
    .mgmt_event_ack(mgmt_event_ack), .critical_event(critical_event),
    .background_hold(background_hold), .space_addr(space_addr), .space_wr(space_wr),
    .space_wdata(space_wdata), .space_rdata(space_rdata)
  );

  hmc_space_model mem_u (
    .clk(clk), .space_addr(space_addr), .space_wr(space_wr),
    .space_wdata(space_wdata), .space_rdata(space_rdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (os_event_interrupt === 1'b1)
      os_cnt++;
    if (management_interrupt === 1'b1)
      mg_cnt++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check8(input hmc_pkg::hmc_byte_t got, input hmc_pkg::hmc_byte_t exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic host_read(input logic sel, output hmc_pkg::hmc_byte_t b);
    host_sel_cmd = sel;
    step(1);
    host_rd = 1'b1;
    step(5);
    check8({7'h00, host_rdata_oe}, 8'h01);
    b = host_rdata;
    host_rd = 1'b0;
    step(5);
    check8({7'h00, host_rdata_oe}, 8'h00);
  endtask

  // poll status until input_full is clear, then strobe one byte
  task automatic host_write(input logic sel, input hmc_pkg::hmc_byte_t b);
    hmc_pkg::hmc_byte_t st;
    int k;
    st = 8'h02;
    k = 0;
    while (st[1] !== 1'b0 && k < 50)
    begin
      host_read(1'b1, st);
      k++;
    end
    if (k == 50)
      failures++;
    host_sel_cmd = sel;
    host_wdata = b;
    step(1);
    host_wr = 1'b1;
    step(4);
    host_wr = 1'b0;
    step(4);
  endtask

  task automatic wait_obf(output hmc_pkg::hmc_byte_t st);
    int k;
    st = 8'h00;
    k = 0;
    while (st[0] !== 1'b1 && k < 50)
    begin
      host_read(1'b1, st);
      k++;
    end
    if (k == 50)
      failures++;
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end

  initial
  begin
    failures = 0;
    n_compared = 0;
    os_cnt = 0;
    mg_cnt = 0;
    rst_n = 1'b0;
    host_sel_cmd = 1'b0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 8'h00;
    os_event_req = 1'b0;
    os_event_code = 8'h00;
    mgmt_event_req = 1'b0;
    mgmt_event_ack = 1'b0;
    critical_event = 1'b0;
    step(12);
    mem_u.mem[8'h34] = 8'h5C;
    rst_n = 1'b1;
    step(4);
    host_read(1'b1, s);
    check8(s, 8'h00);
    $display("test reset done");

    c = os_cnt;
    host_write(1'b1, 8'h81);
    host_write(1'b0, 8'h12);
    host_write(1'b0, 8'hA5);
    step(2);
    check8(mem_u.mem[8'h12], 8'hA5);
    check8(8'(os_cnt - c), 8'h03);
    host_read(1'b1, s);
    check8(s, 8'h00);
    $display("test write done");

    c = os_cnt;
    host_write(1'b1, 8'h80);
    host_write(1'b0, 8'h34);
    wait_obf(s);
    check8(s, 8'h01);
    check8(8'(os_cnt - c), 8'h02);
    host_read(1'b0, s);
    check8(s, 8'h5C);
    host_read(1'b1, s);
    check8(s, 8'h00);
    $display("test read done");

    os_event_code = 8'h3C;
    c = os_cnt;
    os_event_req = 1'b1;
    step(1);
    os_event_req = 1'b0;
    step(4);
    check8(8'(os_cnt - c), 8'h01);
    mgmt_event_req = 1'b1;
    step(1);
    mgmt_event_req = 1'b0;
    step(4);
    check8(8'(mg_cnt), 8'h01);
    host_read(1'b1, s);
    check8(s, 8'h60);
    mgmt_event_ack = 1'b1;
    step(1);
    mgmt_event_ack = 1'b0;
    step(2);
    host_read(1'b1, s);
    check8(s, 8'h20);
    $display("test events done");

    // query result left unread, so the burst command must stall in input
    host_write(1'b1, 8'h84);
    wait_obf(s);
    check8(s, 8'h09);
    host_write(1'b1, 8'h82);
    host_read(1'b1, s);
    check8(s, 8'h0B);
    host_read(1'b0, s);
    check8(s, 8'h3C);
    wait_obf(s);
    check8(s, 8'h19);
    host_read(1'b0, s);
    check8(s, 8'h90);
    check8({7'h00, background_hold}, 8'h01);
    host_write(1'b1, 8'h55);
    host_read(1'b1, s);
    check8(s, 8'h18);
    c = os_cnt;
    host_write(1'b1, 8'h83);
    host_read(1'b1, s);
    check8(s, 8'h08);
    check8(8'(os_cnt - c), 8'h01);
    $display("test burst done");

    host_write(1'b1, 8'h82);
    wait_obf(s);
    host_read(1'b0, s);
    c = os_cnt;
    step(1100);
    host_read(1'b1, s);
    check8(s, 8'h08);
    check8(8'(os_cnt - c), 8'h01);
    $display("test burst timeout done");

    host_write(1'b1, 8'h82);
    wait_obf(s);
    host_read(1'b0, s);
    check8(s, 8'h90);
    c = os_cnt;
    critical_event = 1'b1;
    step(3);
    check8({7'h00, background_hold}, 8'h00);
    host_read(1'b1, s);
    check8(s, 8'h08);
    check8(8'(os_cnt - c), 8'h01);
    critical_event = 1'b0;
    host_write(1'b1, 8'h84);
    wait_obf(s);
    host_read(1'b0, s);
    check8(s, 8'h00);
    $display("test critical and empty query done");
    finish_test;
  end
endmodule
